/* hdl/hlc_config_bank.sv */
// Contract
// - Base address nibble is read-only, bits 7:4
// - Port one pages 0/1 at 0xB0/0xB1
// - Port one pages 2/3 at 0xB2/0xB3
// - Fast port uses 0xB4-0xB7 likewise
// - Bit 3 sets four-wire read direction level
// - Bit 2 selects four-wire clock phase
// - Bit 1 selects four-wire clock idle level
// - Bit 0 sets select input polarity
// - Link settings writable only while unlocked
// - Bit 7 picks two-wire or four-wire link
// - Bit 6 gives continuous high-speed mode
// - Bit 5 gives fast-mode-plus timing
// - Bit 3 sets interrupt output polarity
// - Bit 2 selects push-pull or open drain
// - Hysteresis code at bits 6:4
// - Lower threshold code at bits 3:0
// - Bit 2 enables buck active discharge
// - Bits 1:0 choose first regulator track
// - Fuse lock freezes 0x104 to 0x117
`timescale 1ns/100ps
`include "hlc_consts.svh"

module hlc_config_bank (
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic link_clk_i,
    input wire logic link_srst_i,
    input wire logic link_req_i,
    input wire logic link_we_i,
    input wire logic [`HLC_ADDR_W-1:0] link_addr_i,
    input wire logic [`HLC_DATA_W-1:0] link_wdata_i,
    output logic link_busy_o,
    output logic link_done_o,
    output logic [`HLC_DATA_W-1:0] link_rdata_o,
    input wire logic application_fuse_lock_i,
    input wire logic [7:0] pm_port_addr_i,
    input wire logic [7:0] hs_port_addr_i,
    input wire logic direction_bit_i,
    input wire logic select_pin_i,
    input wire logic irq_req_i,
    input wire logic reset_req_i,
    output hlc_pkg::hlc_match_t pm_port_match_o,
    output hlc_pkg::hlc_match_t hs_port_match_o,
    output logic four_wire_read_o,
    output logic select_active_o,
    output logic direction_bit_polarity_o,
    output logic clock_phase_o,
    output logic clock_idle_high_o,
    output logic select_polarity_o,
    output logic link_two_wire_o,
    output logic pm_port_high_speed_continuous_o,
    output logic pm_port_fast_plus_o,
    output logic pm_port_supply_select_o,
    output logic output_supply_select_o,
    output logic input_supply_select_o,
    output logic interrupt_request_out_o,
    output logic interrupt_request_out_oe_o,
    output logic reset_out_o,
    output logic reset_out_oe_o,
    output logic [2:0] fault_hysteresis_code_o,
    output logic [3:0] fault_lower_threshold_code_o,
    output logic peripheral_buck_clock_invert_o,
    output logic io_buck_clock_invert_o,
    output logic memory_buck_clock_invert_o,
    output logic processor_buck_clock_invert_o,
    output logic core_one_buck_clock_invert_o,
    output logic core_two_buck_clock_invert_o,
    output logic buck_active_discharge_enable_o,
    output logic [1:0] first_regulator_track_select_o
);

    // Core-side handshake state, read back by the link side
    logic ack_tgl;
    logic [`HLC_DATA_W-1:0] rdata_hold;

    // Link domain
    // Request fields stay frozen in req_hold until the ack returns to the link side
    hlc_pkg::hlc_req_t req_hold;
    hlc_pkg::hlc_link_state_t link_state;
    logic req_tgl;
    logic ack_s1;
    logic ack_s2;
    logic ack_s3;
    logic [`HLC_DATA_W-1:0] rdata_seen;

    wire ack_arrived = (ack_s2 == ack_s3) && (ack_s3 == req_tgl);
    wire link_take = (link_state == hlc_pkg::HLC_IDLE) && link_req_i;

    always_ff @(posedge link_clk_i) begin
        if (link_srst_i) begin
            req_hold <= '0;
            req_tgl <= 1'b0;
            link_state <= hlc_pkg::HLC_IDLE;
        end else begin
            case (link_state)
                hlc_pkg::HLC_IDLE: begin
                    if (link_req_i) begin
                        req_hold <= '{we: link_we_i, addr: link_addr_i, wdata: link_wdata_i};
                        req_tgl <= ~req_tgl;
                        link_state <= hlc_pkg::HLC_WAIT;
                    end
                end
                hlc_pkg::HLC_WAIT: begin
                    if (ack_arrived) begin
                        link_state <= hlc_pkg::HLC_IDLE;
                    end
                end
                default: link_state <= hlc_pkg::HLC_IDLE;
            endcase
        end
    end

    // Acknowledge toggle and read data cross back; data is stable once the ack settles
    always_ff @(posedge link_clk_i) begin
        if (link_srst_i) begin
            ack_s1 <= 1'b0;
            ack_s2 <= 1'b0;
            ack_s3 <= 1'b0;
        end else begin
            ack_s1 <= ack_tgl;
            ack_s2 <= ack_s1;
            ack_s3 <= ack_s2;
        end
    end

    wire link_finish = (link_state == hlc_pkg::HLC_WAIT) && ack_arrived;

    always_ff @(posedge link_clk_i) begin
        if (link_srst_i) begin
            link_busy_o <= 1'b0;
            link_done_o <= 1'b0;
            link_rdata_o <= `HLC_READ_ZERO;
        end else begin
            link_busy_o <= link_take || ((link_state == hlc_pkg::HLC_WAIT) && !ack_arrived);
            link_done_o <= link_finish;
            if (link_finish) begin
                link_rdata_o <= rdata_seen;
            end
        end
    end

    assign rdata_seen = rdata_hold;

    // Core domain
    logic req_s1;
    logic req_s2;
    logic req_s3;
    logic [3:0] setup_low;
    logic [7:0] linkpin;
    logic [7:0] fault;
    logic [7:0] conv;

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            req_s1 <= 1'b0;
            req_s2 <= 1'b0;
            req_s3 <= 1'b0;
        end else begin
            req_s1 <= req_tgl;
            req_s2 <= req_s1;
            req_s3 <= req_s2;
        end
    end

    // Request is new once the two settled stages agree and differ from the ack
    wire core_go = (req_s2 == req_s3) && (req_s3 != ack_tgl);
    wire core_we = core_go && req_hold.we;
    wire [`HLC_ADDR_W-1:0] core_addr = req_hold.addr;
    wire [`HLC_DATA_W-1:0] core_wdata = req_hold.wdata;

    wire sel_setup = (core_addr == `HLC_OFS_SETUP);
    wire sel_linkpin = (core_addr == `HLC_OFS_LINKPIN);
    wire sel_fault = (core_addr == `HLC_OFS_FAULT);
    wire sel_conv = (core_addr == `HLC_OFS_CONV);
    // Fuse lock is a steady core-domain level, so it is used without a sync
    wire in_lock_range = (core_addr >= `HLC_LOCK_LO) && (core_addr <= `HLC_LOCK_HI);
    wire unlocked = !(application_fuse_lock_i && in_lock_range);

    wire wr_setup = core_we && sel_setup && unlocked;
    wire wr_linkpin = core_we && sel_linkpin && unlocked;
    wire wr_fault = core_we && sel_fault && unlocked;
    wire wr_conv = core_we && sel_conv && unlocked;

    wire [7:0] setup_view = {`HLC_BASE_NIBBLE, setup_low};

    // Unmapped addresses read back as zero
    wire [`HLC_DATA_W-1:0] rd_mux =
        sel_setup ? setup_view :
        sel_linkpin ? linkpin :
        sel_fault ? fault :
        sel_conv ? conv : `HLC_READ_ZERO;

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            ack_tgl <= 1'b0;
            rdata_hold <= `HLC_READ_ZERO;
        end else if (core_go) begin
            // Every request completes, even a write that was dropped
            ack_tgl <= ~ack_tgl;
            rdata_hold <= req_hold.we ? `HLC_READ_ZERO : rd_mux;
        end
    end

    // Base nibble has no storage, so writes cannot reach it
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            setup_low <= `HLC_SETUP_LOW_RST;
        end else if (wr_setup) begin
            setup_low <= core_wdata[`HLC_SETUP_DIRPOL:`HLC_SETUP_CSPOL];
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            linkpin <= `HLC_LINKPIN_RST;
        end else if (wr_linkpin) begin
            linkpin <= core_wdata;
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            fault <= `HLC_FAULT_RST;
        end else if (wr_fault) begin
            fault <= core_wdata;
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            conv <= `HLC_CONV_RST;
        end else if (wr_conv) begin
            conv <= core_wdata;
        end
    end

    // Two-wire address decode: nibble, port code, page pair, direction
    // Both ports share one decode; only the port code differs
    wire [7:0] tw_addr [2];
    wire [1:0] tw_port [2];
    wire hlc_pkg::hlc_match_t next_tw_match [2];

    assign tw_addr[0] = pm_port_addr_i;
    assign tw_addr[1] = hs_port_addr_i;
    assign tw_port[0] = `HLC_PORT_PM;
    assign tw_port[1] = `HLC_PORT_HS;

    for (genvar gi = 0; gi < 2; gi++) begin : g_tw_decode
        wire base_ok = (tw_addr[gi][`HLC_TW_BASE_HI:`HLC_TW_BASE_LO] == `HLC_BASE_NIBBLE);
        wire port_ok = (tw_addr[gi][`HLC_TW_PORT_HI:`HLC_TW_PORT_LO] == tw_port[gi]);
        assign next_tw_match[gi] = '{hit: base_ok && port_ok,
                                     upper_pages: tw_addr[gi][`HLC_TW_PAGE],
                                     read: tw_addr[gi][`HLC_TW_DIR]};
    end

    // Four-wire decode; direction comes from same-clock shift logic
    wire next_four_wire_read = (direction_bit_i == setup_low[`HLC_SETUP_DIRPOL]);

    // Select pin is asynchronous: three stages, a level counts once stages two and three agree
    logic sel_s1;
    logic sel_s2;
    logic sel_s3;
    logic sel_level;

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            sel_s1 <= 1'b0;
            sel_s2 <= 1'b0;
            sel_s3 <= 1'b0;
            sel_level <= 1'b0;
        end else begin
            sel_s1 <= select_pin_i;
            sel_s2 <= sel_s1;
            sel_s3 <= sel_s2;
            if (sel_s2 == sel_s3) begin
                sel_level <= sel_s3;
            end
        end
    end

    wire next_select_active = (sel_level == setup_low[`HLC_SETUP_CSPOL]);

    // Output pins: interrupt level follows polarity, reset is always active low; open drain only pulls low
    wire irq_level = irq_req_i ? linkpin[`HLC_LP_IRQPOL] : ~linkpin[`HLC_LP_IRQPOL];
    wire rst_level = ~reset_req_i;
    wire open_drain = linkpin[`HLC_LP_ODRAIN];
    wire next_irq_out = open_drain ? 1'b0 : irq_level;
    wire next_irq_oe = open_drain ? ~irq_level : 1'b1;
    wire next_rst_out = open_drain ? 1'b0 : rst_level;
    wire next_rst_oe = open_drain ? ~rst_level : 1'b1;

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            pm_port_match_o <= '0;
            hs_port_match_o <= '0;
            four_wire_read_o <= 1'b0;
            select_active_o <= 1'b0;
            interrupt_request_out_o <= 1'b0;
            interrupt_request_out_oe_o <= 1'b0;
            reset_out_o <= 1'b0;
            reset_out_oe_o <= 1'b1;
        end else begin
            pm_port_match_o <= next_tw_match[0];
            hs_port_match_o <= next_tw_match[1];
            four_wire_read_o <= next_four_wire_read;
            select_active_o <= next_select_active;
            interrupt_request_out_o <= next_irq_out;
            interrupt_request_out_oe_o <= next_irq_oe;
            reset_out_o <= next_rst_out;
            reset_out_oe_o <= next_rst_oe;
        end
    end

    // Configuration outputs are registered copies, core two as the inverse of core one, one clock behind the store
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            direction_bit_polarity_o <= 1'b0;
            clock_phase_o <= 1'b0;
            clock_idle_high_o <= 1'b0;
            select_polarity_o <= 1'b0;
            link_two_wire_o <= 1'b0;
            pm_port_high_speed_continuous_o <= 1'b0;
            pm_port_fast_plus_o <= 1'b0;
            pm_port_supply_select_o <= 1'b0;
            output_supply_select_o <= 1'b0;
            input_supply_select_o <= 1'b0;
        end else begin
            direction_bit_polarity_o <= setup_low[`HLC_SETUP_DIRPOL];
            clock_phase_o <= setup_low[`HLC_SETUP_CPHA];
            clock_idle_high_o <= setup_low[`HLC_SETUP_CPOL];
            select_polarity_o <= setup_low[`HLC_SETUP_CSPOL];
            link_two_wire_o <= linkpin[`HLC_LP_TYPE];
            pm_port_high_speed_continuous_o <= linkpin[`HLC_LP_HSM];
            pm_port_fast_plus_o <= linkpin[`HLC_LP_FMP];
            pm_port_supply_select_o <= linkpin[`HLC_LP_IFV];
            output_supply_select_o <= linkpin[`HLC_LP_OV];
            input_supply_select_o <= linkpin[`HLC_LP_IV];
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            fault_hysteresis_code_o <= '0;
            fault_lower_threshold_code_o <= '0;
            peripheral_buck_clock_invert_o <= 1'b0;
            io_buck_clock_invert_o <= 1'b0;
            memory_buck_clock_invert_o <= 1'b0;
            processor_buck_clock_invert_o <= 1'b0;
            core_one_buck_clock_invert_o <= 1'b0;
            core_two_buck_clock_invert_o <= 1'b1;
            buck_active_discharge_enable_o <= 1'b0;
            first_regulator_track_select_o <= '0;
        end else begin
            fault_hysteresis_code_o <= fault[`HLC_FLT_HYST_HI:`HLC_FLT_HYST_LO];
            fault_lower_threshold_code_o <= fault[`HLC_FLT_LOW_HI:`HLC_FLT_LOW_LO];
            peripheral_buck_clock_invert_o <= conv[`HLC_CV_PERI];
            io_buck_clock_invert_o <= conv[`HLC_CV_IO];
            memory_buck_clock_invert_o <= conv[`HLC_CV_MEM];
            // Processor polarity is kept as written; opposing memory is software's job
            processor_buck_clock_invert_o <= conv[`HLC_CV_PRO];
            core_one_buck_clock_invert_o <= conv[`HLC_CV_CORE1];
            core_two_buck_clock_invert_o <= ~conv[`HLC_CV_CORE1];
            buck_active_discharge_enable_o <= conv[`HLC_CV_DISCH];
            first_regulator_track_select_o <= conv[`HLC_CV_TRK_HI:`HLC_CV_TRK_LO];
        end
    end

endmodule : hlc_config_bank

/* hdl/hlc_consts.svh */
`ifndef HLC_CONSTS_SVH
`define HLC_CONSTS_SVH

`define HLC_ADDR_W 9
`define HLC_DATA_W 8

`define HLC_OFS_SETUP 9'h105
`define HLC_OFS_LINKPIN 9'h106
`define HLC_OFS_FAULT 9'h107
`define HLC_OFS_CONV 9'h108
`define HLC_LOCK_LO 9'h104
`define HLC_LOCK_HI 9'h117

`define HLC_BASE_NIBBLE 4'hb
`define HLC_SETUP_LOW_RST 4'h0
`define HLC_LINKPIN_RST 8'h80
`define HLC_FAULT_RST 8'h00
`define HLC_CONV_RST 8'h00
`define HLC_READ_ZERO 8'h00

`define HLC_SETUP_BASE_HI 7
`define HLC_SETUP_BASE_LO 4
`define HLC_SETUP_DIRPOL 3
`define HLC_SETUP_CPHA 2
`define HLC_SETUP_CPOL 1
`define HLC_SETUP_CSPOL 0

`define HLC_LP_TYPE 7
`define HLC_LP_HSM 6
`define HLC_LP_FMP 5
`define HLC_LP_IFV 4
`define HLC_LP_IRQPOL 3
`define HLC_LP_ODRAIN 2
`define HLC_LP_OV 1
`define HLC_LP_IV 0

`define HLC_FLT_HYST_HI 6
`define HLC_FLT_HYST_LO 4
`define HLC_FLT_LOW_HI 3
`define HLC_FLT_LOW_LO 0

`define HLC_CV_PERI 7
`define HLC_CV_IO 6
`define HLC_CV_MEM 5
`define HLC_CV_PRO 4
`define HLC_CV_CORE1 3
`define HLC_CV_DISCH 2
`define HLC_CV_TRK_HI 1
`define HLC_CV_TRK_LO 0

`define HLC_TW_BASE_HI 7
`define HLC_TW_BASE_LO 4
`define HLC_TW_PORT_HI 3
`define HLC_TW_PORT_LO 2
`define HLC_TW_PAGE 1
`define HLC_TW_DIR 0

`define HLC_PORT_PM 2'h0
`define HLC_PORT_HS 2'h1

`endif

/* hdl/hlc_pkg.sv */
`include "hlc_consts.svh"

package hlc_pkg;

    typedef struct packed {
        logic we;
        logic [`HLC_ADDR_W-1:0] addr;
        logic [`HLC_DATA_W-1:0] wdata;
    } hlc_req_t;

    typedef struct packed {
        logic hit;
        logic upper_pages;
        logic read;
    } hlc_match_t;

    typedef enum logic {
        HLC_IDLE,
        HLC_WAIT
    } hlc_link_state_t;

endpackage : hlc_pkg

/* dv/hlc_checker_properties.sv */
`timescale 1ns/100ps
module hlc_checker (
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic link_clk_i,
    input wire logic link_srst_i,
    input wire logic link_req_i,
    input wire logic link_busy_o,
    input wire logic link_done_o,
    input wire logic [7:0] link_rdata_o,
    input wire logic [7:0] pm_port_addr_i,
    input wire logic [7:0] hs_port_addr_i,
    input wire logic reset_req_i,
    input wire hlc_pkg::hlc_match_t pm_port_match_o,
    input wire hlc_pkg::hlc_match_t hs_port_match_o,
    input wire logic reset_out_o,
    input wire logic reset_out_oe_o,
    input wire logic core_one_buck_clock_invert_o,
    input wire logic core_two_buck_clock_invert_o
);
    pm_decode_a:
    assert property (@(posedge clock_i) disable iff (srst_i) !$past(srst_i) |->
        pm_port_match_o.hit == ($past(pm_port_addr_i[7:2]) == 6'h2c)) else $error("pm hit wrong");
    hs_decode_a:
    assert property (@(posedge clock_i) disable iff (srst_i) !$past(srst_i) |->
        hs_port_match_o.hit == ($past(hs_port_addr_i[7:2]) == 6'h2d)) else $error("hs hit wrong");
    decode_fields_a:
    assert property (@(posedge clock_i) disable iff (srst_i) pm_port_match_o.hit |->
        pm_port_match_o[1:0] == $past(pm_port_addr_i[1:0])) else $error("pm fields wrong");
    reset_pin_a:
    assert property (@(posedge clock_i) disable iff (srst_i) !$past(srst_i) |->
        (reset_out_oe_o ? reset_out_o : 1'b1) == !$past(reset_req_i)) else $error("reset pin");
    core_two_a:
    assert property (@(posedge clock_i) disable iff (srst_i)
        core_two_buck_clock_invert_o == !core_one_buck_clock_invert_o) else $error("core two");
    take_a:
    assert property (@(posedge link_clk_i) disable iff (link_srst_i)
        link_req_i && !link_busy_o |=> link_busy_o) else $error("request not taken");
    done_bound_a:
    assert property (@(posedge link_clk_i) disable iff (link_srst_i)
        $rose(link_busy_o) |-> ##[1:300] link_done_o) else $error("access never done");
    done_end_a:
    assert property (@(posedge link_clk_i) disable iff (link_srst_i) !$past(link_srst_i) |->
        link_done_o == $fell(link_busy_o)) else $error("done and busy disagree");
    rdata_hold_a:
    assert property (@(posedge link_clk_i) disable iff (link_srst_i)
        !$past(link_srst_i) && !link_done_o |-> $stable(link_rdata_o)) else $error("rdata moved");
endmodule : hlc_checker

bind hlc_config_bank hlc_checker u_chk (.*);

/* dv/hlc_host_model.sv */
`timescale 1ns/100ps
module hlc_host_model (
    input wire logic link_clk_i,
    input wire logic link_busy_i,
    input wire logic link_done_i,
    input wire logic [7:0] link_rdata_i,
    output logic link_req_o = 1'b0,
    output logic link_we_o = 1'b0,
    output logic [8:0] link_addr_o = 9'h000,
    output logic [7:0] link_wdata_o = 8'h00
);
    // Fields are scrambled once taken so a late sample cannot pass
    task automatic access(input logic w, input logic [8:0] a, input logic [7:0] d,
            output logic [7:0] q, output logic ok);
        ok = 1'b0;
        q = 8'h00;
        @(negedge link_clk_i);
        link_req_o = 1'b1;
        link_we_o = w;
        link_addr_o = a;
        link_wdata_o = d;
        do @(posedge link_clk_i); while (link_busy_i);
        @(negedge link_clk_i);
        link_req_o = 1'b0;
        link_we_o = !w;
        link_addr_o = ~a;
        link_wdata_o = ~d;
        for (int n = 0; n < 400 && !ok; n++) begin
            @(posedge link_clk_i);
            if (link_done_i) begin
                q = link_rdata_i;
                ok = 1'b1;
            end
        end
    endtask : access
endmodule : hlc_host_model

/* dv/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
    logic clock_i = 1'b0;
    logic link_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic link_srst_i = 1'b1;
    logic application_fuse_lock_i = 1'b0;
    logic direction_bit_i = 1'b0;
    logic select_pin_i = 1'b0;
    logic irq_req_i = 1'b0;
    logic reset_req_i = 1'b0;
    logic [7:0] pm_port_addr_i = 8'h00;
    logic [7:0] hs_port_addr_i = 8'h00;
    logic link_req_i, link_we_i, link_busy_o, link_done_o;
    logic [8:0] link_addr_i;
    logic [7:0] link_wdata_i, link_rdata_o;
    hlc_pkg::hlc_match_t pm_port_match_o, hs_port_match_o;
    logic four_wire_read_o, select_active_o, direction_bit_polarity_o, clock_phase_o;
    logic clock_idle_high_o, select_polarity_o, link_two_wire_o, pm_port_fast_plus_o;
    logic pm_port_high_speed_continuous_o, pm_port_supply_select_o, output_supply_select_o;
    logic input_supply_select_o, interrupt_request_out_o, interrupt_request_out_oe_o;
    logic reset_out_o, reset_out_oe_o, peripheral_buck_clock_invert_o, io_buck_clock_invert_o;
    logic memory_buck_clock_invert_o, processor_buck_clock_invert_o;
    logic core_one_buck_clock_invert_o, core_two_buck_clock_invert_o;
    logic buck_active_discharge_enable_o;
    logic [2:0] fault_hysteresis_code_o;
    logic [3:0] fault_lower_threshold_code_o;
    logic [1:0] first_regulator_track_select_o;
    logic [7:0] e [4];
    logic [7:0] m [4] = '{8'h0f, 8'hf3, 8'h7f, 8'hff};
    wire [7:0] o [4];
    logic [31:0] seed = 32'd81811;
    int failures = 0;
    int n_tests = 0;
    int cyc = 0;

    assign o[0] = {4'h0, direction_bit_polarity_o, clock_phase_o, clock_idle_high_o,
        select_polarity_o};
    assign o[1] = {link_two_wire_o, pm_port_high_speed_continuous_o, pm_port_fast_plus_o,
        pm_port_supply_select_o, 2'h0, output_supply_select_o, input_supply_select_o};
    assign o[2] = {1'b0, fault_hysteresis_code_o, fault_lower_threshold_code_o};
    assign o[3] = {peripheral_buck_clock_invert_o, io_buck_clock_invert_o,
        memory_buck_clock_invert_o, processor_buck_clock_invert_o, core_one_buck_clock_invert_o,
        buck_active_discharge_enable_o, first_regulator_track_select_o};

    always #50 clock_i = ~clock_i;
    always begin
        #1.3;
        forever #3 link_clk_i = ~link_clk_i;
    end

    hlc_config_bank DUT (.*);
    hlc_host_model u_host (.link_clk_i, .link_busy_i(link_busy_o), .link_done_i(link_done_o),
        .link_rdata_i(link_rdata_o), .link_req_o(link_req_i), .link_we_o(link_we_i),
        .link_addr_o(link_addr_i), .link_wdata_o(link_wdata_i));

    function automatic logic [7:0] rnd();
        repeat (8) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[7:0];
    endfunction : rnd

    task automatic chk(input logic [7:0] g, input logic [7:0] x);
        n_tests++;
        if (g !== x) begin
            failures++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask : chk

    task automatic chk_dec(input hlc_pkg::hlc_match_t g, input logic [7:0] a, input logic [1:0] p);
        logic h;
        h = a[7:2] == {4'hb, p};
        chk({5'h0, g.hit, h ? g[1:0] : 2'h0}, {5'h0, h, h ? a[1:0] : 2'h0});
    endtask : chk_dec

    task automatic acc(input logic w, input logic [8:0] a, input logic [7:0] d,
            output logic [7:0] q);
        logic ok;
        u_host.access(w, a, d, q, ok);
        chk({7'h0, ok}, 8'h01);
    endtask : acc

    // Pin expectation: push-pull drives the level, open drain only pulls low
    function automatic logic [7:0] pin_exp(input logic od, input logic lv);
        return od ? {6'h0, !lv, 1'b0} : {6'h0, 1'b1, lv};
    endfunction : pin_exp

    task automatic check_outs();
        logic lv;
        lv = irq_req_i ? e[1][3] : !e[1][3];
        for (int r = 0; r < 4; r++) begin
            chk(o[r], e[r] & m[r]);
        end
        chk({6'h0, interrupt_request_out_oe_o, interrupt_request_out_o},
            pin_exp(e[1][2], lv));
        chk({6'h0, reset_out_oe_o, reset_out_o}, pin_exp(e[1][2], !reset_req_i));
        chk({7'h0, core_two_buck_clock_invert_o}, {7'h0, !e[3][3]});
        chk({6'h0, four_wire_read_o, select_active_o},
            {6'h0, direction_bit_i == e[0][3], select_pin_i == e[0][0]});
    endtask : check_outs

    task automatic wrap_up();
        $display("checks=%0d mismatches=%0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : wrap_up

    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 6000) begin
            failures++;
            wrap_up();
        end
    end

    initial begin
        logic [7:0] q;
        logic [7:0] d;
        e = '{8'hb0, 8'h80, 8'h00, 8'h00};
        repeat (16) @(posedge clock_i);
        @(negedge clock_i);
        srst_i = 1'b0;
        @(negedge link_clk_i);
        link_srst_i = 1'b0;
        repeat (3) @(negedge clock_i);
        check_outs();
        for (int r = 0; r < 4; r++) begin
            acc(1'b0, 9'h105 + 9'(r), 8'h00, q);
            chk(q, e[r]);
        end
        for (int k = 0; k < 14; k++) begin
            for (int r = 0; r < 4; r++) begin
                d = rnd();
                if (r == 3) d[4] = !d[5];
                acc(1'b1, 9'h105 + 9'(r), d, q);
                e[r] = (r == 0) ? {4'hb, d[3:0]} : d;
                acc(1'b0, 9'h105 + 9'(r), 8'h00, q);
                chk(q, e[r]);
            end
            @(negedge clock_i);
            d = rnd();
            direction_bit_i = d[0];
            select_pin_i = d[1];
            irq_req_i = d[2];
            reset_req_i = d[3];
            pm_port_addr_i = (k < 8) ? 8'hb0 + 8'(k) : rnd();
            hs_port_addr_i = (k < 8) ? 8'hb7 - 8'(k) : {4'hb, d[7:4]};
            repeat (6) @(negedge clock_i);
            check_outs();
            chk_dec(pm_port_match_o, pm_port_addr_i, 2'h0);
            chk_dec(hs_port_match_o, hs_port_addr_i, 2'h1);
        end
        @(negedge clock_i);
        application_fuse_lock_i = 1'b1;
        for (int r = 0; r < 4; r++) begin
            acc(1'b1, 9'h105 + 9'(r), ~e[r], q);
            acc(1'b0, 9'h105 + 9'(r), 8'h00, q);
            chk(q, e[r]);
        end
        acc(1'b1, 9'h1ff, 8'h5a, q);
        acc(1'b0, 9'h1ff, 8'h00, q);
        chk(q, 8'h00);
        repeat (3) @(negedge clock_i);
        check_outs();
        wrap_up();
    end
endmodule : tb_top
